// ### rtt_pkg.sv
// package: types and constants for the relay trip test and fault indication block
package rtt_pkg;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned SHORT_PRESS_MS = 1000;
   localparam int unsigned LONG_PRESS_MS = 5000;
   localparam int unsigned FAULT_DELAY_MS = 10;
   localparam int unsigned SHORT_CYC = (CLK_HZ / 1000) * SHORT_PRESS_MS;
   localparam int unsigned LONG_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;
   localparam int unsigned FAULT_CYC = (CLK_HZ / 1000) * FAULT_DELAY_MS;
   localparam int unsigned CNT_W = 32;

   // -------------------------------------------------------------
   // stage layout
   // -------------------------------------------------------------
   localparam int unsigned NSTAGE = 4;
   localparam int unsigned NPOS = 2 * NSTAGE;
   localparam int unsigned POS_W = 4;
   localparam logic [POS_W-1:0] POS_NONE = 4'h0;
   localparam int unsigned CODE_W = 4;
   localparam logic [CODE_W-1:0] CODE_IDLE = 4'h0;
   localparam int unsigned FCODE_W = 10;
   localparam int unsigned FCODE_VAR = 169;

   // button press events from the timer
   typedef struct packed {
      logic short_rel;
      logic long_hit;
      logic held_short;
   } rtt_press_t;

   typedef enum logic [1:0] {RTT_NORMAL, RTT_TEST} rtt_mode_t;
endpackage

// ### rtt_press_timer.sv
// press duration timer for one push button
module rtt_press_timer
   import rtt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic btn_i,
   input wire logic [CNT_W-1:0] short_thr_i,
   input wire logic [CNT_W-1:0] long_thr_i,
   output rtt_press_t press_o
);
   logic [CNT_W-1:0] cnt_q;
   logic long_done_q;

   // hold counter saturates at the long threshold
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !btn_i) begin
         cnt_q <= '0;
      end else if (cnt_q < long_thr_i) begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   // a long hold fires once; its release must not also count as short
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !btn_i) begin
         long_done_q <= 1'b0;
      end else if (cnt_q == long_thr_i - 32'h1) begin
         long_done_q <= 1'b1;
      end
   end

   always_comb begin
      press_o.long_hit = btn_i && (cnt_q == long_thr_i - 32'h1);
      press_o.short_rel = !btn_i && (cnt_q >= short_thr_i) && !long_done_q;
      press_o.held_short = btn_i && (cnt_q >= short_thr_i);
   end
endmodule // rtt_press_timer

// ### rtt_trip_test.sv
// trip test sequencer, operation indicators and self-supervision fault state
module rtt_trip_test
   import rtt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic prog_btn_i,
   input wire logic step_btn_i,
   input wire logic reset_btn_i,
   input wire logic [CNT_W-1:0] short_thr_i,
   input wire logic [CNT_W-1:0] long_thr_i,
   input wire logic [NSTAGE-1:0] stage_start_i,
   input wire logic [NSTAGE-1:0] stage_trip_i,
   input wire logic [NSTAGE-1:0] trip_to_main_i,
   input wire logic fault_detect_i,
   input wire logic [FCODE_W-1:0] fault_code_i,
   output logic test_flash_o,
   output logic [POS_W-1:0] sel_pos_o,
   output logic [NSTAGE-1:0] start_out_o,
   output logic [NSTAGE-1:0] trip_out_o,
   output logic trip_led_o,
   output logic internal_fault_output_o,
   output logic fault_led_o,
   output logic protect_inhibit_o,
   output logic fault_code_valid_o,
   output logic [FCODE_W-1:0] fault_code_o,
   output logic [NSTAGE*CODE_W-1:0] stage_code_o
);
   import rtt_pkg::*;

   // ------------------------------------------------------------
   // button timing
   // ------------------------------------------------------------
   rtt_press_t prog_ev;
   rtt_press_t step_ev;
   rtt_mode_t mode_q;
   logic [POS_W-1:0] pos_q;
   logic both_q;
   logic fault_q;
   logic [CNT_W-1:0] fcnt_q;

   // hold durations measured in module clocks against inputs
   rtt_press_timer u_prog (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .btn_i(prog_btn_i),
      .short_thr_i(short_thr_i),
      .long_thr_i(long_thr_i),
      .press_o(prog_ev)
   );

   rtt_press_timer u_step (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .btn_i(step_btn_i),
      .short_thr_i(short_thr_i),
      .long_thr_i(long_thr_i),
      .press_o(step_ev)
   );

   // ------------------------------------------------------------
   // test mode and selection
   // ------------------------------------------------------------
   // long program hold toggles test mode at any step
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         mode_q <= RTT_NORMAL;
      end else if (prog_ev.long_hit && !step_btn_i) begin
         mode_q <= (mode_q == RTT_NORMAL) ? RTT_TEST : RTT_NORMAL;
      end
   end

   // once both were pressed, the release is not a selection step
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || (!prog_btn_i && !step_btn_i)) begin
         both_q <= 1'b0;
      end else if (prog_btn_i && step_btn_i) begin
         both_q <= 1'b1;
      end
   end

   // position 0 = none, odd = start, even = trip of stage (pos-1)/2
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || mode_q != RTT_TEST) begin
         pos_q <= POS_NONE;
      end else if (prog_ev.short_rel && !both_q) begin
         if (pos_q == POS_W'(NPOS)) begin
            pos_q <= POS_NONE;
         end else begin
            pos_q <= pos_q + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // forced outputs, held only while both buttons stay down
   // ------------------------------------------------------------
   logic both_now;
   assign both_now = prog_btn_i && step_btn_i && mode_q == RTT_TEST && !fault_q;

   generate
      for (genvar s = 0; s < NSTAGE; s++) begin : g_force
         logic [POS_W-1:0] sp;
         logic [POS_W-1:0] tp;
         assign sp = POS_W'(2 * s + 1);
         assign tp = POS_W'(2 * s + 2);
         // protection signals pass through unless fault inhibits
         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               start_out_o[s] <= 1'b0;
               trip_out_o[s] <= 1'b0;
            end else begin
               start_out_o[s] <= !fault_q && (stage_start_i[s]
                  || (both_now && pos_q == sp));
               trip_out_o[s] <= !fault_q && (stage_trip_i[s]
                  || (both_now && pos_q == tp));
            end
         end
         // latched indicator: start code, then operate code
         // a live stage beats the reset button, so an active indication is never lost
         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               stage_code_o[s*CODE_W +: CODE_W] <= CODE_IDLE;
            end else if (trip_out_o[s]) begin
               stage_code_o[s*CODE_W +: CODE_W] <= CODE_W'(2 * s + 2);
            end else if (start_out_o[s] && (reset_btn_i
               || stage_code_o[s*CODE_W +: CODE_W] == CODE_IDLE)) begin
               stage_code_o[s*CODE_W +: CODE_W] <= CODE_W'(2 * s + 1);
            end else if (reset_btn_i) begin
               stage_code_o[s*CODE_W +: CODE_W] <= CODE_IDLE;
            end
         end
      end
   endgenerate

   // main trip relay drives the trip led; it latches like indicators
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         trip_led_o <= 1'b0;
      end else if (|(trip_out_o & trip_to_main_i)) begin
         trip_led_o <= 1'b1;
      end else if (reset_btn_i) begin
         trip_led_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // self-supervision
   // ------------------------------------------------------------
   // a short settle delay filters glitches before declaring a fault
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !fault_detect_i) begin
         fcnt_q <= '0;
         fault_q <= 1'b0;
      end else if (fcnt_q < CNT_W'(FAULT_CYC)) begin
         fcnt_q <= fcnt_q + 32'h1;
      end else begin
         fault_q <= 1'b1;
      end
   end

   // fault code is not touched by the reset button
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         fault_code_o <= '0;
         fault_code_valid_o <= 1'b0;
      end else begin
         fault_code_valid_o <= fault_q;
         if (fault_q) begin
            fault_code_o <= fault_code_i;
         end
      end
   end

   // fault output: real fault or step held in the none position
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         internal_fault_output_o <= 1'b0;
         fault_led_o <= 1'b0;
         protect_inhibit_o <= 1'b0;
      end else begin
         internal_fault_output_o <= fault_q || (mode_q == RTT_TEST
            && pos_q == POS_NONE && step_ev.held_short && !prog_btn_i);
         fault_led_o <= fault_q || (mode_q == RTT_TEST
            && pos_q == POS_NONE && step_ev.held_short && !prog_btn_i);
         protect_inhibit_o <= fault_q;
      end
   end

   // display state
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         test_flash_o <= 1'b0;
         sel_pos_o <= POS_NONE;
      end else begin
         test_flash_o <= mode_q == RTT_TEST;
         sel_pos_o <= pos_q;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_force_release: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (!prog_btn_i || !step_btn_i) && stage_trip_i == '0 |=> trip_out_o == '0)
      else $error("forced trip held without both buttons");
   chk_fault_inhibit: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      fault_q |=> start_out_o == '0 && protect_inhibit_o)
      else $error("protection not inhibited in fault");
   chk_code_reset_keep: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      fault_q && reset_btn_i |=> fault_code_valid_o)
      else $error("fault code lost on reset button");
   chk_wrap_none: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      mode_q == RTT_TEST && pos_q == POS_W'(NPOS) && prog_ev.short_rel && !both_q
      |=> pos_q == POS_NONE)
      else $error("selection did not wrap to none");
   chk_step_fault: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !fault_q && !step_btn_i |=> !internal_fault_output_o)
      else $error("fault output held after step release");
   chk_mode_toggle: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      prog_ev.long_hit && !step_btn_i |=> mode_q != $past(mode_q))
      else $error("long hold did not toggle test mode");
   chk_ind_latch: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      trip_out_o[0] |=> stage_code_o[CODE_W-1:0] == 4'h2)
      else $error("operate code not shown");
   chk_reset_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      reset_btn_i && start_out_o == '0 && trip_out_o == '0
      |=> stage_code_o == '0 && !trip_led_o)
      else $error("indicators not cleared by reset");
endmodule // rtt_trip_test

// ### rtt_operator.sv
// operator model: presses the front panel buttons of the relay module
module rtt_operator
(
   input wire logic ref_clk_i,
   output logic prog_btn_o,
   output logic step_btn_o,
   output logic reset_btn_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------
   // button handling
   // ----------------------------------------------------------
   // all buttons released at time zero
   initial begin
      prog_btn_o = 1'b0;
      step_btn_o = 1'b0;
      reset_btn_o = 1'b0;
   end

   // buttons move only just after an edge, so the sampler never sees a half change
   task automatic drive(input logic p, input logic s, input logic r);
      @(posedge ref_clk_i);
      #1;
      prog_btn_o = p;
      step_btn_o = s;
      reset_btn_o = r;
   endtask

   // press a chord for n + 1 cycles, then let go of every button
   task automatic hold(input logic p, input logic s, input logic r, input int n);
      drive(p, s, r);
      repeat (n) @(posedge ref_clk_i);
      drive(1'b0, 1'b0, 1'b0);
   endtask
endmodule // rtt_operator

// ### tb_relay_trip_test_and_fault_indication.sv
// testbench: trip test sequence, indicators and press timing of the relay block
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin err_count++; \
   $display("[ERR] %0t act=%0h exp=%0h", $time, (act), (exp)); end end
module tb_relay_trip_test_and_fault_indication;
   timeunit 1ns;
   timeprecision 100ps;
   import rtt_pkg::*;

   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   localparam int SHORT = 10;
   localparam int LONG = 50;
   logic clk, srst, prog, step, rst_btn, fdet, tflash, tled, ifault, fled, inh, fvalid;
   logic [NSTAGE-1:0] st_in, tr_in, to_main, st_out, tr_out;
   logic [POS_W-1:0] pos;
   logic [FCODE_W-1:0] fcode, fcode_out;
   logic [NSTAGE*CODE_W-1:0] code;
   int err_count = 0;
   int compares = 0;

   rtt_operator i_op (.ref_clk_i(clk), .prog_btn_o(prog), .step_btn_o(step),
      .reset_btn_o(rst_btn));
   // fault input only glitches: the 10 ms settle delay is too long to reach in this run
   rtt_trip_test i_dut (.ref_clk_i(clk), .srst_i(srst), .prog_btn_i(prog),
      .step_btn_i(step), .reset_btn_i(rst_btn), .short_thr_i(32'(SHORT)),
      .long_thr_i(32'(LONG)), .stage_start_i(st_in), .stage_trip_i(tr_in),
      .trip_to_main_i(to_main), .fault_detect_i(fdet), .fault_code_i(fcode),
      .test_flash_o(tflash), .sel_pos_o(pos), .start_out_o(st_out), .trip_out_o(tr_out),
      .trip_led_o(tled), .internal_fault_output_o(ifault), .fault_led_o(fled),
      .protect_inhibit_o(inh), .fault_code_valid_o(fvalid), .fault_code_o(fcode_out),
      .stage_code_o(code));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // short press stays well clear of the long threshold
   task automatic short_press();
      i_op.hold(1'b1, 1'b0, 1'b0, SHORT + 5);
      wait_cyc(3);
   endtask

   task automatic long_press();
      i_op.hold(1'b1, 1'b0, 1'b0, LONG + 5);
      wait_cyc(4);
   endtask

   task automatic end_sim();
      if (err_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_fault_force();
      long_press();
      `CHK(tflash, 1'b1);
      `CHK(pos, POS_NONE);
      i_op.drive(1'b0, 1'b1, 1'b0);
      wait_cyc(SHORT - 3);
      `CHK(ifault, 1'b0);
      wait_cyc(6);
      `CHK(ifault, 1'b1);
      `CHK(fled, 1'b1);
      i_op.drive(1'b0, 1'b0, 1'b0);
      wait_cyc(3);
      `CHK(ifault, 1'b0);
      `CHK(fled, 1'b0);
   endtask

   // force start then trip of stage 0; trip routed to the main relay
   task automatic t_force_stage();
      short_press();
      `CHK(pos, 4'h1);
      i_op.drive(1'b1, 1'b1, 1'b0);
      wait_cyc(3);
      `CHK(st_out, 4'h1);
      `CHK(code[3:0], 4'h1);
      i_op.drive(1'b0, 1'b0, 1'b0);
      wait_cyc(3);
      `CHK(st_out, 4'h0);
      short_press();
      `CHK(pos, 4'h2);
      i_op.drive(1'b1, 1'b1, 1'b0);
      wait_cyc(3);
      `CHK(tr_out, 4'h1);
      `CHK(tled, 1'b1);
      `CHK(code[3:0], 4'h2);
      i_op.drive(1'b0, 1'b0, 1'b0);
      wait_cyc(3);
      `CHK(tr_out, 4'h0);
      `CHK(tled, 1'b1);
   endtask

   task automatic t_skip_and_exit();
      for (int p = 3; p <= NPOS; p++) begin
         short_press();
         `CHK(pos, POS_W'(p));
         `CHK({st_out, tr_out}, 8'h00);
      end
      short_press();
      `CHK(pos, POS_NONE);
      long_press();
      `CHK(tflash, 1'b0);
      i_op.hold(1'b0, 1'b1, 1'b0, SHORT + 5);
      `CHK(ifault, 1'b0);
   endtask

   // real protection on stage 1: start code, operate code, latch, reset button
   task automatic t_latch();
      st_in = 4'h2;
      wait_cyc(3);
      `CHK(code[7:4], 4'h3);
      tr_in = 4'h2;
      wait_cyc(3);
      `CHK(code[7:4], 4'h4);
      st_in = 4'h0;
      tr_in = 4'h0;
      wait_cyc(3);
      `CHK(code[7:4], 4'h4);
      i_op.hold(1'b0, 1'b0, 1'b1, 2);
      wait_cyc(3);
      `CHK(code, 16'h0000);
      `CHK(tled, 1'b0);
   endtask

   // a short supervision glitch is filtered; an unrouted trip keeps the led dark
   task automatic t_glitch();
      fdet = 1'b1;
      tr_in = 4'h2;
      wait_cyc(20);
      `CHK(tr_out, 4'h2);
      `CHK(inh, 1'b0);
      `CHK(fled, 1'b0);
      `CHK(ifault, 1'b0);
      `CHK(fvalid, 1'b0);
      `CHK(fcode_out, 10'h000);
      `CHK(tled, 1'b0);
      i_op.hold(1'b0, 1'b0, 1'b1, 2);
      wait_cyc(2);
      `CHK(code[7:4], 4'h4);
      fdet = 1'b0;
      tr_in = 4'h0;
      wait_cyc(3);
      `CHK(tr_out, 4'h0);
      `CHK(code[7:4], 4'h4);
   endtask

   // ----------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------
   initial begin
      srst = 1'b1;
      fdet = 1'b0;
      fcode = 10'h2a5;
      st_in = 4'h0;
      tr_in = 4'h0;
      to_main = 4'h1;
      wait_cyc(4);
      srst = 1'b0;
      wait_cyc(1);
      t_fault_force();
      t_force_stage();
      t_skip_and_exit();
      t_latch();
      t_glitch();
      end_sim();
   end

   initial begin
      #100000;
      err_count++;
      end_sim();
   end
endmodule // tb_relay_trip_test_and_fault_indication
